// file: sfcg_defines.svh
// Constants for the serial flash command guard
`ifndef SFCG_DEFINES_SVH
`define SFCG_DEFINES_SVH

`define SFCG_OP_RESUME 8'hab
`define SFCG_OP_IDENT 8'h9f
`define SFCG_OP_SLEEP 8'hb9
`define SFCG_OP_WREN 8'h06
`define SFCG_OP_PP 8'h02
`define SFCG_OP_PP4 8'h12
`define SFCG_OP_SE 8'h20
`define SFCG_OP_SE4 8'h21
`define SFCG_OP_HBE 8'h52
`define SFCG_OP_HBE4 8'h53
`define SFCG_OP_BE 8'hd8
`define SFCG_OP_BE4 8'hdc
`define SFCG_OP_READ 8'h03
`define SFCG_OP_READ4 8'h13
`define SFCG_OP_EN4B 8'hb7
`define SFCG_OP_EX4B 8'hb8
`define SFCG_OP_CE 8'hc7
`define SFCG_OP_WRID 8'h9e
`define SFCG_BYTE_BITS 4'd8
`define SFCG_ADDR3_BYTES 3'd3
`define SFCG_ADDR4_BYTES 3'd4
`define SFCG_MASK_SECTOR 32'hfffff000
`define SFCG_MASK_HALF 32'hffff8000
`define SFCG_MASK_BLOCK 32'hffff0000
`define SFCG_LIMIT_24 32'h00ffffff
`define SFCG_ID_BYTES 4'd8
`define SFCG_LANE3_RESET_BIT 7
`define SFCG_PU_TIME_US 32'd300
`define SFCG_CLK_MHZ 32'd100
`define SFCG_PU_CYCLES (`SFCG_PU_TIME_US * `SFCG_CLK_MHZ)

`endif

// file: sfcg_pkg.sv
// Types for the serial flash command guard
package sfcg_pkg;
    typedef enum logic [2:0] {
        SFCG_IDLE = 3'b000,
        SFCG_OPCODE = 3'b001,
        SFCG_ADDR = 3'b010,
        SFCG_DATA = 3'b011,
        SFCG_DROP = 3'b100
    } sfcg_state_t;

    typedef enum logic [1:0] {
        SFCG_UNIT_NONE = 2'b00,
        SFCG_UNIT_SECTOR = 2'b01,
        SFCG_UNIT_HALF = 2'b10,
        SFCG_UNIT_BLOCK = 2'b11
    } sfcg_unit_t;

    typedef struct packed {
        logic modifying;
        logic four_byte;
        logic has_addr;
        logic ident;
        sfcg_unit_t unit;
    } sfcg_cmd_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [31:0] addr;
        logic modifying;
        sfcg_unit_t unit;
    } sfcg_issue_t;
endpackage : sfcg_pkg

// file: sfcg_sync.sv
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/10ps
`default_nettype none
`include "sfcg_defines.svh"

module sfcg_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule : sfcg_sync
`default_nettype wire

// file: sfcg_guard.sv
// Serial flash command acceptance guard and address decoder
`timescale 1ns/10ps
`default_nettype none
`include "sfcg_defines.svh"

module sfcg_guard #(
    parameter int PU_CYCLES = `SFCG_PU_CYCLES,
    parameter logic [63:0] UNIQUE_ID = 64'h0123456789abcdef  // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Serial link from host
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_oe,
    // Lane-3 and dedicated reset pins, config and strap inputs
    input wire logic quad_lane3_reset_n,
    input wire logic dedicated_reset_n,
    input wire logic dedicated_reset_used,
    input wire logic [7:0] volatile_config_two,
    input wire logic ext_addr_default_nv,
    // Supply monitors
    input wire logic vcc_valid,
    input wire logic vcc_cutoff,
    // Status and issue to the core
    output logic deep_sleep_mode,
    output logic ext_addr_mode,
    output logic powerup_done,
    output logic hw_reset_pulse,
    output logic cmd_valid,
    output sfcg_pkg::sfcg_issue_t cmd_issue
);
    logic sck_s, cs_n_s, si_s, l3_s, rst_s, vok_s, cut_s;

    sfcg_sync #(.WIDTH(7), .RESET_VAL(7'b0101100)) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in({spi_sck, spi_cs_n, spi_si, quad_lane3_reset_n,
                   dedicated_reset_n, vcc_valid, vcc_cutoff}),
        .sync_out({sck_s, cs_n_s, si_s, l3_s, rst_s, vok_s, cut_s})
    );

    function automatic sfcg_pkg::sfcg_cmd_t decode(input logic [7:0] op);
        sfcg_pkg::sfcg_cmd_t c;
        c = '{modifying: 1'b0, four_byte: 1'b0, has_addr: 1'b0, ident: 1'b0,
              unit: sfcg_pkg::SFCG_UNIT_NONE};
        unique case (op)
            `SFCG_OP_PP, `SFCG_OP_WRID: begin
                c.modifying = 1'b1;
                c.has_addr = 1'b1;
            end
            `SFCG_OP_PP4: begin
                c.modifying = 1'b1;
                c.has_addr = 1'b1;
                c.four_byte = 1'b1;
            end
            `SFCG_OP_SE, `SFCG_OP_SE4: begin
                c.modifying = 1'b1;
                c.has_addr = 1'b1;
                c.four_byte = (op == `SFCG_OP_SE4);
                c.unit = sfcg_pkg::SFCG_UNIT_SECTOR;
            end
            `SFCG_OP_HBE, `SFCG_OP_HBE4: begin
                c.modifying = 1'b1;
                c.has_addr = 1'b1;
                c.four_byte = (op == `SFCG_OP_HBE4);
                c.unit = sfcg_pkg::SFCG_UNIT_HALF;
            end
            `SFCG_OP_BE, `SFCG_OP_BE4: begin
                c.modifying = 1'b1;
                c.has_addr = 1'b1;
                c.four_byte = (op == `SFCG_OP_BE4);
                c.unit = sfcg_pkg::SFCG_UNIT_BLOCK;
            end
            `SFCG_OP_READ: c.has_addr = 1'b1;
            `SFCG_OP_READ4: begin
                c.has_addr = 1'b1;
                c.four_byte = 1'b1;
            end
            `SFCG_OP_CE, `SFCG_OP_EN4B, `SFCG_OP_EX4B, `SFCG_OP_SLEEP: c.modifying = 1'b1;
            `SFCG_OP_IDENT: c.ident = 1'b1;
            default: c = c;
        endcase
        decode = c;
    endfunction : decode

    // Control state
    sfcg_pkg::sfcg_state_t state_reg, state_next;
    logic [31:0] pu_cnt_reg, pu_cnt_next;
    logic pu_done_reg, pu_done_next;
    logic sleep_reg, sleep_next;
    logic ext_reg, ext_next;
    logic strap_pend_reg, strap_pend_next;
    logic sck_d_reg, sck_d_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] op_reg, op_next;
    logic [2:0] abytes_reg, abytes_next;
    logic [2:0] acnt_reg, acnt_next;
    logic [31:0] addr_reg, addr_next;
    logic [3:0] id_idx_reg, id_idx_next;
    logic so_reg, so_next;
    logic so_oe_reg, so_oe_next;
    logic valid_reg, valid_next;
    sfcg_pkg::sfcg_issue_t issue_reg, issue_next;
    logic hwrst_reg, hwrst_next;
    logic l3_d_reg, l3_d_next;
    logic rst_d_reg, rst_d_next;

    // Datapath helpers
    sfcg_pkg::sfcg_cmd_t cur;
    logic sck_rise, sck_fall, lane3_en, reset_fall;
    logic [7:0] byte_in;
    logic [7:0] id_byte;

    assign sck_rise = sck_s & ~sck_d_reg;
    assign sck_fall = ~sck_s & sck_d_reg;
    assign lane3_en = volatile_config_two[`SFCG_LANE3_RESET_BIT];
    assign reset_fall = (lane3_en & ~l3_s & l3_d_reg)
        | (dedicated_reset_used & ~rst_s & rst_d_reg);
    assign byte_in = {shift_reg[6:0], si_s};
    assign cur = decode(op_reg);
    assign id_byte = UNIQUE_ID[63 - 8 * id_idx_reg[2:0] -: 8];

    always_comb begin
        state_next = state_reg;
        pu_cnt_next = pu_cnt_reg;
        pu_done_next = pu_done_reg;
        sleep_next = sleep_reg;
        ext_next = ext_reg;
        strap_pend_next = 1'b0;
        sck_d_next = sck_s;
        l3_d_next = l3_s;
        bit_next = bit_reg;
        shift_next = shift_reg;
        op_next = op_reg;
        abytes_next = abytes_reg;
        acnt_next = acnt_reg;
        addr_next = addr_reg;
        id_idx_next = id_idx_reg;
        so_next = so_reg;
        so_oe_next = so_oe_reg;
        valid_next = 1'b0;
        issue_next = issue_reg;
        hwrst_next = 1'b0;
        rst_d_next = rst_s;
        // Strap taken one cycle after reset release
        if (strap_pend_reg) begin
            ext_next = ext_addr_default_nv;
        end
        // Power-up wait, restarts on supply dip; host keeps off meanwhile
        if (!vok_s) begin
            pu_cnt_next = '0;
            pu_done_next = 1'b0;
        end else if (!pu_done_reg) begin
            if (pu_cnt_reg >= PU_CYCLES - 1) begin
                pu_done_next = 1'b1;
            end
            pu_cnt_next = pu_cnt_reg + 32'd1;
        end
        if (reset_fall) begin
            hwrst_next = 1'b1;
            sleep_next = 1'b0;
            ext_next = ext_addr_default_nv;
            state_next = sfcg_pkg::SFCG_IDLE;
            so_oe_next = 1'b0;
        end else if (cs_n_s) begin
            // Frame end: judge modifying commands on the byte count
            if (state_reg == sfcg_pkg::SFCG_DATA && cur.modifying && bit_reg == 3'd0
                && !(cur.has_addr && acnt_reg != abytes_reg)) begin
                valid_next = 1'b1;
                issue_next.opcode = op_reg;
                issue_next.modifying = 1'b1;
                issue_next.unit = cur.unit;
                if (op_reg == `SFCG_OP_EN4B) ext_next = 1'b1;
                if (op_reg == `SFCG_OP_EX4B) ext_next = 1'b0;
                if (op_reg == `SFCG_OP_SLEEP) sleep_next = 1'b1;
            end
            state_next = sfcg_pkg::SFCG_IDLE;
            so_oe_next = 1'b0;
        end else begin
            unique case (state_reg)
                sfcg_pkg::SFCG_IDLE: begin
                    bit_next = 3'd0;
                    acnt_next = 3'd0;
                    id_idx_next = 4'd0;
                    addr_next = '0;
                    // Powerup gate is defensive; already binds the host
                    state_next = (cut_s || !pu_done_reg) ? sfcg_pkg::SFCG_DROP
                                                         : sfcg_pkg::SFCG_OPCODE;
                end
                sfcg_pkg::SFCG_OPCODE: if (sck_rise) begin
                    shift_next = byte_in;
                    bit_next = bit_reg + 3'd1;
                    if (bit_reg == 3'd7) begin
                        op_next = byte_in;
                        state_next = sfcg_pkg::SFCG_DATA;
                        if (sleep_reg) begin
                            if (byte_in == `SFCG_OP_RESUME) sleep_next = 1'b0;
                            state_next = sfcg_pkg::SFCG_DROP;
                        end else if (decode(byte_in).has_addr) begin
                            state_next = sfcg_pkg::SFCG_ADDR;
                            abytes_next = (decode(byte_in).four_byte || ext_reg)
                                ? `SFCG_ADDR4_BYTES : `SFCG_ADDR3_BYTES;
                        end
                        issue_next.opcode = byte_in;
                        issue_next.modifying = decode(byte_in).modifying;
                        issue_next.unit = decode(byte_in).unit;
                        // Outside sleep, opcodes with no address, no modify and no ident are accepted at opcode time; reads wait for the address
                        valid_next = !decode(byte_in).modifying && !sleep_reg
                            && !decode(byte_in).ident && !decode(byte_in).has_addr;
                    end
                end
                sfcg_pkg::SFCG_ADDR: if (sck_rise) begin
                    shift_next = byte_in;
                    bit_next = bit_reg + 3'd1;
                    if (bit_reg == 3'd7) begin
                        addr_next = {addr_reg[23:0], byte_in};
                        acnt_next = acnt_reg + 3'd1;
                        if (acnt_reg + 3'd1 == abytes_reg) begin
                            state_next = sfcg_pkg::SFCG_DATA;
                            // 24-bit mode limits reach to 16 MBytes
                            if (abytes_reg == `SFCG_ADDR3_BYTES)
                                addr_next = {8'h00, addr_reg[15:0], byte_in}
                                    & `SFCG_LIMIT_24;
                            valid_next = !cur.modifying;
                        end
                    end
                end
                sfcg_pkg::SFCG_DATA: begin
                    if (sck_rise) begin
                        shift_next = byte_in;
                        bit_next = bit_reg + 3'd1;
                    end
                    if (cur.ident && sck_fall) begin
                        so_oe_next = 1'b1;
                        so_next = id_byte[3'd7 - bit_reg];
                        if (bit_reg == 3'd7 && id_idx_reg < `SFCG_ID_BYTES - 4'd1)
                            id_idx_next = id_idx_reg + 4'd1;
                    end
                    // Identification space is never a write target
                    if (op_reg == `SFCG_OP_WRID) state_next = sfcg_pkg::SFCG_DROP;
                end
                sfcg_pkg::SFCG_DROP: state_next = sfcg_pkg::SFCG_DROP;
                default: state_next = sfcg_pkg::SFCG_IDLE;
            endcase
        end
        if (valid_next) begin
            unique case (issue_next.unit)
                sfcg_pkg::SFCG_UNIT_SECTOR: issue_next.addr = addr_next & `SFCG_MASK_SECTOR;
                sfcg_pkg::SFCG_UNIT_HALF: issue_next.addr = addr_next & `SFCG_MASK_HALF;
                sfcg_pkg::SFCG_UNIT_BLOCK: issue_next.addr = addr_next & `SFCG_MASK_BLOCK;
                sfcg_pkg::SFCG_UNIT_NONE: issue_next.addr = addr_next;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= sfcg_pkg::SFCG_IDLE;
            pu_cnt_reg <= '0;
            pu_done_reg <= 1'b0;
            sleep_reg <= 1'b0;
            ext_reg <= 1'b0;
            strap_pend_reg <= 1'b1;
            sck_d_reg <= 1'b0;
            l3_d_reg <= 1'b1;
            rst_d_reg <= 1'b1;
            bit_reg <= 3'd0;
            shift_reg <= 8'h00;
            op_reg <= 8'h00;
            abytes_reg <= `SFCG_ADDR3_BYTES;
            acnt_reg <= 3'd0;
            addr_reg <= 32'h00000000;
            id_idx_reg <= 4'd0;
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
            valid_reg <= 1'b0;
            issue_reg <= '0;
            hwrst_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pu_cnt_reg <= pu_cnt_next;
            pu_done_reg <= pu_done_next;
            sleep_reg <= sleep_next;
            ext_reg <= ext_next;
            strap_pend_reg <= strap_pend_next;
            sck_d_reg <= sck_d_next;
            l3_d_reg <= l3_d_next;
            rst_d_reg <= rst_d_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            op_reg <= op_next;
            abytes_reg <= abytes_next;
            acnt_reg <= acnt_next;
            addr_reg <= addr_next;
            id_idx_reg <= id_idx_next;
            so_reg <= so_next;
            so_oe_reg <= so_oe_next;
            valid_reg <= valid_next;
            issue_reg <= issue_next;
            hwrst_reg <= hwrst_next;
        end
    end

    assign spi_so = so_reg;
    assign spi_so_oe = so_oe_reg;
    assign deep_sleep_mode = sleep_reg;
    assign ext_addr_mode = ext_reg;
    assign powerup_done = pu_done_reg;
    assign hw_reset_pulse = hwrst_reg;
    assign cmd_valid = valid_reg;
    assign cmd_issue = issue_reg;
endmodule : sfcg_guard
`default_nettype wire

// file: sfcg_guard_sva.sv
// Checker for the serial flash command guard
`timescale 1ns/10ps
`default_nettype none
module sfcg_guard_sva #(
    parameter int PU_CYCLES = 20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Serial link
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    input wire logic spi_so,
    input wire logic spi_so_oe,
    // Reset pins and straps
    input wire logic quad_lane3_reset_n,
    input wire logic dedicated_reset_n,
    input wire logic dedicated_reset_used,
    input wire logic [7:0] volatile_config_two,
    input wire logic ext_addr_default_nv,
    // Supply monitors
    input wire logic vcc_valid,
    input wire logic vcc_cutoff,
    // Status and issue
    input wire logic deep_sleep_mode,
    input wire logic ext_addr_mode,
    input wire logic powerup_done,
    input wire logic hw_reset_pulse,
    input wire logic cmd_valid,
    input wire sfcg_pkg::sfcg_issue_t cmd_issue
);
    logic [10:0] cut_cnt_reg, cut_cnt_next;
    logic [15:0] up_cnt_reg, up_cnt_next;

    // Saturating, so a long cutoff never wraps back below the threshold
    always_comb begin
        cut_cnt_next = vcc_cutoff ? cut_cnt_reg + {10'h0, ~&cut_cnt_reg} : 11'h0;
        up_cnt_next = up_cnt_reg + {15'h0, ~&up_cnt_reg};
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cut_cnt_reg <= 11'h0;
            up_cnt_reg <= 16'h0;
        end else begin
            cut_cnt_reg <= cut_cnt_next;
            up_cnt_reg <= up_cnt_next;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_cutoff_drop: assert property (cut_cnt_reg >= 11'h3e8 |-> !cmd_valid)
        else $error("command taken under supply cutoff");
    a_early_cmd: assert property (cmd_valid |-> up_cnt_reg >= PU_CYCLES)
        else $error("command taken before power-up wait");
    a_byte_frame: assert property (cmd_valid && cmd_issue.modifying |->
        $past(spi_cs_n, 2))
        else $error("modifying command issued before frame end");
    a_sleep_only: assert property (cmd_valid && deep_sleep_mode &&
        $past(deep_sleep_mode) |-> cmd_issue.opcode == 8'hab)
        else $error("command other than resume taken in sleep");
    a_lane3_reset: assert property ($fell(quad_lane3_reset_n) &&
        volatile_config_two[7] |-> ##[1:6] hw_reset_pulse)
        else $error("enabled lane-3 reset gave no pulse");
    a_pin_reset: assert property ($fell(dedicated_reset_n) &&
        dedicated_reset_used |-> ##[1:6] hw_reset_pulse)
        else $error("dedicated reset pin gave no pulse");
    a_reset_wake: assert property (hw_reset_pulse |-> ##[0:2] !deep_sleep_mode)
        else $error("hardware reset left sleep mode set");
    a_addr_24: assert property (cmd_valid && !ext_addr_mode &&
        cmd_issue.opcode inside {8'h02, 8'h03, 8'h20, 8'h52, 8'hd8}
        |-> cmd_issue.addr[31:24] == 8'h00)
        else $error("legacy address beyond 16 MB");
    a_sector_align: assert property (cmd_valid &&
        cmd_issue.unit == sfcg_pkg::SFCG_UNIT_SECTOR |-> cmd_issue.addr[11:0] == 12'h000)
        else $error("sector erase address not aligned");
    a_half_align: assert property (cmd_valid &&
        cmd_issue.unit == sfcg_pkg::SFCG_UNIT_HALF |-> cmd_issue.addr[14:0] == 15'h0000)
        else $error("half block erase address not aligned");
    a_block_align: assert property (cmd_valid &&
        cmd_issue.unit == sfcg_pkg::SFCG_UNIT_BLOCK |-> cmd_issue.addr[15:0] == 16'h0000)
        else $error("block erase address not aligned");
    a_ident_write: assert property (cmd_valid |-> cmd_issue.opcode != 8'h9e)
        else $error("write to identification space taken");
    a_ext_default: assert property ($fell(sys_rst) |->
        ##2 ext_addr_mode == ext_addr_default_nv)
        else $error("address mode not loaded from default");
endmodule : sfcg_guard_sva

bind sfcg_guard sfcg_guard_sva #(.PU_CYCLES(PU_CYCLES)) u_sva (
    .clk_sys, .sys_rst, .spi_sck, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe,
    .quad_lane3_reset_n, .dedicated_reset_n, .dedicated_reset_used,
    .volatile_config_two, .ext_addr_default_nv, .vcc_valid, .vcc_cutoff,
    .deep_sleep_mode, .ext_addr_mode, .powerup_done, .hw_reset_pulse,
    .cmd_valid, .cmd_issue
);
`default_nettype wire

// file: sfcg_host_model.sv
// Behavioural host controller driving the serial link
`timescale 1ns/10ps
`default_nettype none
module sfcg_host_model (
    // Serial link
    output var logic spi_sck,
    output var logic spi_cs_n,
    output var logic spi_si,
    input wire logic spi_so,
    // Pace
    input wire logic slow
);
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end

    // Clock stands low between frames; the caller waits for power-up first
    task automatic frame(input logic [79:0] d, input int n, output logic [79:0] q);
        realtime hd;
        hd = slow ? 100.0 : 62.5;
        q = '0;
        spi_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            spi_si = d[i];
            #(hd);
            spi_sck = 1'b1;
            q = {q[78:0], spi_so};
            #(hd);
            spi_sck = 1'b0;
        end
        // Flipped so a stale bit is never taken for data
        spi_si = ~spi_si;
        #(hd);
        spi_cs_n = 1'b1;
    endtask : frame
endmodule : sfcg_host_model
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the serial flash command guard
`timescale 1ns/10ps
`default_nettype none
`define check_eq(what, exp, got) \
    compares++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("ERROR %s expected %0h got %0h", what, exp, got); \
    end
module tb_top;
    localparam int PU_CYCLES = 20;
    localparam logic [63:0] ID = 64'h5ac317e904b2d86f; // Arbitrary value
    typedef struct {
        int n;
        logic [79:0] d;
        int nv;
        logic [31:0] a;
        logic [1:0] u;
        logic m;
    } sfcg_row_t;
    logic clk_sys, sys_rst, spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe;
    logic quad_lane3_reset_n, dedicated_reset_n, dedicated_reset_used, ext_addr_default_nv;
    logic vcc_valid, vcc_cutoff, deep_sleep_mode, ext_addr_mode, powerup_done;
    logic hw_reset_pulse, cmd_valid, slow;
    logic [7:0] volatile_config_two;
    logic [79:0] rx;
    sfcg_pkg::sfcg_issue_t cmd_issue, seen;
    int num_errors = 0;
    int compares = 0;
    int nvalid = 0;
    int npulse = 0;
    int noe = 0;
    // Unit codes: 0 none, 1 sector, 2 half block, 3 block
    sfcg_row_t rows [11] = '{
        '{32, 80'h20123456, 1, 32'h00123000, 2'h1, 1'b1},
        '{32, 80'h5212abcd, 1, 32'h00128000, 2'h2, 1'b1},
        '{32, 80'hd8345678, 1, 32'h00340000, 2'h3, 1'b1},
        '{40, 80'h02ffffff5a, 1, 32'h00ffffff, 2'h0, 1'b1},
        '{40, 80'h2101234567, 1, 32'h01234000, 2'h1, 1'b1},
        '{40, 80'hdc01abcdef, 1, 32'h01ab0000, 2'h3, 1'b1},
        '{32, 80'h03abcdef, 1, 32'h00abcdef, 2'h0, 1'b0},
        '{40, 80'h131fedcba9, 1, 32'h1fedcba9, 2'h0, 1'b0},
        '{31, 80'h10091a2b, 0, 32'h0, 2'h0, 1'b0},
        '{33, 80'h04002001, 0, 32'h0, 2'h0, 1'b0},
        '{40, 80'h9e0000005a, 0, 32'h0, 2'h0, 1'b0}
    };

    sfcg_guard #(.PU_CYCLES(PU_CYCLES), .UNIQUE_ID(ID)) uut (
        .clk_sys, .sys_rst, .spi_sck, .spi_cs_n, .spi_si, .spi_so, .spi_so_oe,
        .quad_lane3_reset_n, .dedicated_reset_n, .dedicated_reset_used,
        .volatile_config_two, .ext_addr_default_nv, .vcc_valid, .vcc_cutoff,
        .deep_sleep_mode, .ext_addr_mode, .powerup_done, .hw_reset_pulse,
        .cmd_valid, .cmd_issue
    );
    sfcg_host_model host (.spi_sck, .spi_cs_n, .spi_si, .spi_so, .slow);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (cmd_valid === 1'b1) begin
            nvalid++;
            seen = cmd_issue;
        end
        if (hw_reset_pulse === 1'b1) begin
            npulse++;
        end
        noe += int'(spi_so_oe === 1'b1);
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick

    // Twenty cycles covers the few-cycle answer after chip select rises
    task automatic send(input logic [79:0] d, input int n);
        nvalid = 0;
        host.frame(d, n, rx);
        tick(20);
    endtask : send

    task automatic wait_up;
        for (int k = 0; k < 200 && powerup_done !== 1'b1; k++) begin
            tick(1);
        end
        if (powerup_done !== 1'b1) begin
            num_errors++;
            $display("ERROR power-up never completed");
            report_and_stop();
        end
    endtask : wait_up

    // Pulls the lane-3 pin, or the dedicated pin when ded is set
    task automatic pull_reset(input logic ded);
        npulse = 0;
        quad_lane3_reset_n = ded;
        dedicated_reset_n = ~ded;
        tick(10);
        quad_lane3_reset_n = 1'b1;
        dedicated_reset_n = 1'b1;
        tick(10);
    endtask : pull_reset

    task automatic report_and_stop;
        $display("Comparisons %0d, errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        sys_rst = 1'b1;
        vcc_valid = 1'b0;
        vcc_cutoff = 1'b0;
        quad_lane3_reset_n = 1'b1;
        dedicated_reset_n = 1'b1;
        dedicated_reset_used = 1'b0;
        volatile_config_two = 8'h00;
        ext_addr_default_nv = 1'b0;
        slow = 1'b0;
        tick(4);
        sys_rst = 1'b0;
        vcc_valid = 1'b1;
        `check_eq("powerup early", 1'b0, powerup_done)
        wait_up();
        foreach (rows[i]) begin
            send(rows[i].d, rows[i].n);
            `check_eq("accept count", rows[i].nv, nvalid)
            if (rows[i].nv == 1) begin
                `check_eq("opcode", rows[i].d[rows[i].n-1 -: 8], seen.opcode)
                `check_eq("address", rows[i].a, seen.addr)
                `check_eq("unit", rows[i].u, seen.unit)
                `check_eq("modify flag", rows[i].m, seen.modifying)
            end
        end
        // Extended mode switched on and off by command
        send(80'hb7, 8);
        `check_eq("ext mode on", 1'b1, ext_addr_mode)
        send(80'h2002345678, 40);
        `check_eq("ext erase addr", 32'h02345000, seen.addr)
        send(80'hb8, 8);
        `check_eq("ext mode off", 1'b0, ext_addr_mode)
        // Sleep filtering and reset exit
        send(80'hb9, 8);
        send(80'h20001000, 32);
        `check_eq("erase in sleep", 0, nvalid)
        `check_eq("asleep", 1'b1, deep_sleep_mode)
        send(80'hab, 8);
        `check_eq("resumed", 1'b0, deep_sleep_mode)
        send(80'hb9, 8);
        pull_reset(1'b0);
        `check_eq("reset disabled", 0, npulse)
        `check_eq("still asleep", 1'b1, deep_sleep_mode)
        volatile_config_two = 8'h80;
        pull_reset(1'b0);
        `check_eq("reset by config", 1, npulse)
        `check_eq("woken by config", 1'b0, deep_sleep_mode)
        volatile_config_two = 8'h00;
        dedicated_reset_used = 1'b1;
        wait_up();
        send(80'hb9, 8);
        pull_reset(1'b0);
        `check_eq("lane3 ignored", 0, npulse)
        pull_reset(1'b1);
        `check_eq("reset by pin", 1, npulse)
        `check_eq("woken by pin", 1'b0, deep_sleep_mode)
        dedicated_reset_used = 1'b0;
        wait_up();
        // Supply cutoff drops everything
        vcc_cutoff = 1'b1;
        tick(1000);
        send(80'h20001000, 32);
        `check_eq("erase under cutoff", 0, nvalid)
        send(80'h03001000, 32);
        `check_eq("read under cutoff", 0, nvalid)
        vcc_cutoff = 1'b0;
        tick(10);
        // Identity read at the slow pace
        slow = 1'b1;
        host.frame(80'h9f0000000000000000, 72, rx);
        slow = 1'b0;
        tick(20);
        `check_eq("unique id", ID, rx[63:0])
        `check_eq("id not issued", 0, nvalid)
        `check_eq("so driven", 1'b1, noe > 0)
        `check_eq("so released", 1'b0, spi_so_oe)
        // Mid-run reset with 32-bit default
        ext_addr_default_nv = 1'b1;
        sys_rst = 1'b1;
        tick(4);
        sys_rst = 1'b0;
        tick(3);
        `check_eq("ext default", 1'b1, ext_addr_mode)
        wait_up();
        send(80'h0312abcdef, 40);
        `check_eq("legacy 32-bit addr", 32'h12abcdef, seen.addr)
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
